// ### verilog/vdc_pkg.sv
// Shared types and constants for the video DRAM host controller.
// Assumes one 20 MHz clock and a synchronous active-high reset in all users.
// How it works
// - Host refreshes all 512 rows each 16.7ms.
// - Refresh cycles spread evenly, not in bursts.
// - Counter-driven refresh: 512 cycles, no address.
// - Row-only refresh: host supplies row address.
// - Hidden refresh: column low, row toggles.
// - Eighteen-bit address sent as row, column halves.
// - Fresh write mask given at every row strobe.
package vdc_pkg;

    localparam int CLK_NS = 50;
    localparam int ROW_COUNT = 512;
    localparam int REFRESH_PERIOD_NS = 16_700_000;
    // A longest gap rounds down.
    localparam int REFRESH_GAP_CYC = REFRESH_PERIOD_NS / ROW_COUNT / CLK_NS;
    // A least phase time rounds up.
    localparam int PHASE_NS = 100;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SHIFT_HALF_NS = 200;
    localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int LANES = 4;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_MWRITE = 2'h2,
        OP_XFER = 2'h3
    } vdc_op_type;

    typedef struct packed {
        vdc_op_type op;
        logic [2*ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mask;
    } vdc_req_type;

    typedef struct packed {
        logic row_strobe_n;
        logic [LANES-1:0] col_strobe_n;
        logic [ADDR_W-1:0] addr;
        logic transfer_output_enable_n;
        logic mask_write_enable_n;
        logic special_function_select;
        logic shift_port_gate_n;
        logic shift_clock;
    } vdc_pins_type;

    localparam vdc_pins_type PINS_IDLE = '{
        row_strobe_n: 1'b1,
        col_strobe_n: 4'hF,
        addr: 9'h000,
        transfer_output_enable_n: 1'b1,
        mask_write_enable_n: 1'b1,
        special_function_select: 1'b0,
        shift_port_gate_n: 1'b1,
        shift_clock: 1'b0
    };

endpackage

// ### verilog/vdc_fifo.sv
// Word FIFO with a registered read port and valid/ready on both sides.
// Assumes both sides share clk_in.
`timescale 1ns/1ps
`default_nettype none
module vdc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign in_ready_out = (count_q != CW'(DEPTH));
    assign push = in_valid_in && in_ready_out;
    // The output register refills whenever it is empty or being drained.
    assign pop = (count_q != '0) && (!out_valid_out || out_ready_in);

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end else if (pop) begin
            out_valid_out <= 1'b1;
            out_data_out <= mem_q[rd_ptr_q];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end
endmodule // vdc_fifo
`default_nettype wire

// ### verilog/vdc_host.sv
// Host-side controller that drives a dual-port video DRAM module by its pins.
// Assumes the module's pins are wired directly; all pin inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module vdc_host #(
    parameter int REFRESH_GAP = vdc_pkg::REFRESH_GAP_CYC,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire vdc_pkg::vdc_req_type req_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [vdc_pkg::DATA_W-1:0] rd_data_out,
    input wire logic stream_enable_in,
    output logic stream_valid_out,
    output logic [vdc_pkg::DATA_W-1:0] stream_data_out,
    input wire logic stream_ready_in,
    output logic half_status_out,
    output vdc_pkg::vdc_pins_type pins_out,
    input wire logic [vdc_pkg::DATA_W-1:0] dram_data_lines_in,
    output logic [vdc_pkg::DATA_W-1:0] dram_data_lines_out,
    output logic dram_data_lines_oe_n_out,
    input wire logic [vdc_pkg::DATA_W-1:0] serial_out_lines_in,
    input wire logic half_status_flag_in
);
    // ========================================================================
    // State and request latch
    // ========================================================================
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ROW = 6'h02,
        ST_COL = 6'h04,
        ST_PRE = 6'h08,
        ST_CBRC = 6'h10,
        ST_CBRR = 6'h20
    } vdc_state_type;

    localparam int TW = 4;
    localparam logic [TW-1:0] PHASE = TW'(vdc_pkg::PHASE_CYC);
    localparam int RW = $clog2(REFRESH_GAP + 1);

    vdc_state_type state_q;
    vdc_state_type state_d;
    logic [TW-1:0] timer_q;
    vdc_pkg::vdc_req_type req_q;
    logic [RW-1:0] ref_cnt_q;
    logic ref_due_q;
    logic phase_done;
    logic first_cycle;

    assign phase_done = (timer_q == '0);
    assign first_cycle = (timer_q == PHASE);
    assign req_ready_out = (state_q == ST_IDLE) && !ref_due_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (ref_due_q) begin
                    state_d = ST_CBRC;
                end else if (req_valid_in) begin
                    state_d = ST_ROW;
                end
            end
            ST_ROW: begin
                if (phase_done) begin
                    state_d = ST_COL;
                end
            end
            ST_COL: begin
                if (phase_done) begin
                    state_d = ST_PRE;
                end
            end
            ST_CBRC: begin
                if (phase_done) begin
                    state_d = ST_CBRR;
                end
            end
            ST_CBRR: begin
                if (phase_done) begin
                    state_d = ST_PRE;
                end
            end
            ST_PRE: begin
                if (phase_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
        end else begin
            state_q <= state_d;
            timer_q <= (state_d != state_q) ? PHASE : (phase_done ? '0 : timer_q - 1'b1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            req_q <= '0;
        end else if (req_valid_in && req_ready_out) begin
            req_q <= req_in;
        end
    end

    // ========================================================================
    // Refresh pacing
    // ========================================================================
    // One counter-driven refresh per gap gives all rows within the period.
    // Transfers and accesses also refresh rows, but the pacing ignores that
    // credit so the guarantee never hangs on the user's access pattern.
    // Row-only and hidden refresh are never issued, so no refresh row is kept.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ref_cnt_q <= RW'(REFRESH_GAP - 1);
            ref_due_q <= 1'b0;
        end else begin
            ref_cnt_q <= (ref_cnt_q == '0) ? RW'(REFRESH_GAP - 1) : ref_cnt_q - 1'b1;
            if (ref_cnt_q == '0) begin
                ref_due_q <= 1'b1;
            end else if (state_q == ST_IDLE) begin
                ref_due_q <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Pin sequencing
    // ========================================================================
    vdc_pkg::vdc_pins_type pins_d;
    logic [vdc_pkg::DATA_W-1:0] dq_d;
    logic dq_oe_n_d;
    logic sc_q;
    logic gate_n_q;

    always_comb begin
        pins_d = vdc_pkg::PINS_IDLE;
        pins_d.shift_clock = sc_q;
        pins_d.shift_port_gate_n = gate_n_q;
        dq_d = '0;
        dq_oe_n_d = 1'b1;
        case (state_q)
            ST_ROW: begin
                // Row half goes out one cycle before the row strobe falls.
                pins_d.addr = req_q.addr[2*vdc_pkg::ADDR_W-1:vdc_pkg::ADDR_W];
                pins_d.row_strobe_n = first_cycle;
                // Controls are set before the strobe edge that samples them.
                pins_d.transfer_output_enable_n = (req_q.op != vdc_pkg::OP_XFER);
                pins_d.mask_write_enable_n = (req_q.op != vdc_pkg::OP_MWRITE);
                pins_d.special_function_select = 1'b0;
                if (req_q.op == vdc_pkg::OP_MWRITE) begin
                    // Mask is resent every cycle since the device forgets it.
                    dq_d = req_q.mask;
                    dq_oe_n_d = 1'b0;
                end
            end
            ST_COL: begin
                pins_d.row_strobe_n = 1'b0;
                pins_d.addr = req_q.addr[vdc_pkg::ADDR_W-1:0];
                if (!first_cycle) begin
                    pins_d.col_strobe_n = (req_q.op == vdc_pkg::OP_XFER) ? 4'h0 : ~req_q.lanes;
                end
                // Block write is never used, so select stays low at column strobe.
                pins_d.special_function_select = 1'b0;
                case (req_q.op)
                    vdc_pkg::OP_READ: begin
                        // Output enable falls after the row strobe.
                        pins_d.transfer_output_enable_n = first_cycle;
                    end
                    vdc_pkg::OP_WRITE, vdc_pkg::OP_MWRITE: begin
                        // Write enable is low before the column strobe falls.
                        pins_d.mask_write_enable_n = 1'b0;
                        dq_d = req_q.data;
                        dq_oe_n_d = 1'b0;
                    end
                    default: begin
                        pins_d.transfer_output_enable_n = 1'b1;
                    end
                endcase
            end
            ST_CBRC: begin
                // Column strobes lead; no address or data needed.
                pins_d.col_strobe_n = 4'h0;
            end
            ST_CBRR: begin
                pins_d.col_strobe_n = 4'h0;
                pins_d.row_strobe_n = 1'b0;
            end
            default: begin
                pins_d.row_strobe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pins_out <= vdc_pkg::PINS_IDLE;
            dram_data_lines_out <= '0;
            dram_data_lines_oe_n_out <= 1'b1;
        end else begin
            pins_out <= pins_d;
            dram_data_lines_out <= dq_d;
            dram_data_lines_oe_n_out <= dq_oe_n_d;
        end
    end

    // ========================================================================
    // Read data capture
    // ========================================================================
    logic [vdc_pkg::DATA_W-1:0] dq_s1_q;
    logic [vdc_pkg::DATA_W-1:0] dq_s2_q;
    // Marks the last column cycle of a read, delayed to match the two sync flops.
    logic [1:0] rd_pipe_q;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            rd_pipe_q <= '0;
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
        end else begin
            dq_s1_q <= dram_data_lines_in;
            dq_s2_q <= dq_s1_q;
            rd_pipe_q[0] <= (state_q == ST_COL) && phase_done && (req_q.op == vdc_pkg::OP_READ);
            rd_pipe_q[1] <= rd_pipe_q[0];
            rd_valid_out <= rd_pipe_q[1];
            if (rd_pipe_q[1]) begin
                rd_data_out <= dq_s2_q;
            end
        end
    end

    // ========================================================================
    // Serial port
    // ========================================================================
    // The serial side runs on its own, unaffected by the random-access state.
    localparam int SW = 4;
    logic [SW-1:0] sc_div_q;
    logic [vdc_pkg::DATA_W-1:0] ser_s1_q;
    logic [vdc_pkg::DATA_W-1:0] ser_s2_q;
    logic half_s1_q;
    logic fifo_ready;
    logic sc_tick;
    logic push;

    assign sc_tick = (sc_div_q == '0);
    // The word from the last rising edge has been stable half a period by the fall.
    assign push = sc_tick && sc_q && !gate_n_q;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ser_s1_q <= '0;
            ser_s2_q <= '0;
            half_s1_q <= 1'b0;
            half_status_out <= 1'b0;
        end else begin
            ser_s1_q <= serial_out_lines_in;
            ser_s2_q <= ser_s1_q;
            half_s1_q <= half_status_flag_in;
            half_status_out <= half_s1_q;
        end
    end

    // The shift clock stalls while the FIFO is full, so no word is dropped.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sc_div_q <= SW'(vdc_pkg::SHIFT_HALF_CYC - 1);
            sc_q <= 1'b0;
            gate_n_q <= 1'b1;
        end else begin
            gate_n_q <= !stream_enable_in;
            if (!sc_tick) begin
                sc_div_q <= sc_div_q - 1'b1;
            end else if (!gate_n_q && fifo_ready) begin
                sc_div_q <= SW'(vdc_pkg::SHIFT_HALF_CYC - 1);
                sc_q <= !sc_q;
            end else if (sc_q) begin
                sc_div_q <= SW'(vdc_pkg::SHIFT_HALF_CYC - 1);
                sc_q <= 1'b0;
            end
        end
    end

    vdc_fifo #(
        .WIDTH(vdc_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(push && fifo_ready),
        .in_data_in(ser_s2_q),
        .in_ready_out(fifo_ready),
        .out_valid_out(stream_valid_out),
        .out_data_out(stream_data_out),
        .out_ready_in(stream_ready_in)
    );
endmodule // vdc_host
`default_nettype wire

// ### tb/vdc_chk.sv
// Concurrent checks on the host controller's pin sequencing, bound into vdc_host.
// Assumes one clock domain and the pin struct registered by the host.
`timescale 1ns/1ps
`default_nettype none
module vdc_chk #(
    parameter int REFRESH_GAP = 20
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire vdc_pkg::vdc_req_type req_in,
    input wire logic req_ready_out,
    input wire logic rd_valid_out,
    input wire logic stream_enable_in,
    input wire vdc_pkg::vdc_pins_type pins_out,
    input wire logic dram_data_lines_oe_n_out
);
    // ====================================================================
    // Helper state
    logic take;
    logic [8:0] row_q;
    logic [8:0] col_q;
    logic row_n_q;
    int gap_q;
    assign take = req_valid_in && req_ready_out;
    always_ff @(posedge clk_in) begin
        if (take) begin
            row_q <= req_in.addr[17:9];
            col_q <= req_in.addr[8:0];
        end
    end
    // Cycles since the last counter-driven refresh started.
    always_ff @(posedge clk_in) begin
        row_n_q <= pins_out.row_strobe_n;
        if (sys_rst_in || (row_n_q && !pins_out.row_strobe_n && pins_out.col_strobe_n != 4'hF)) begin
            gap_q <= 0;
        end else begin
            gap_q <= gap_q + 1;
        end
    end
    // ====================================================================
    // Assertions
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_reset_idle: assert property (
        $fell(sys_rst_in) |-> pins_out == vdc_pkg::PINS_IDLE && dram_data_lines_oe_n_out)
        else $error("pins not idle after reset");
    a_refresh_gap: assert property (
        gap_q < REFRESH_GAP + 24) else $error("refresh overdue");
    a_cbr_order: assert property (
        $fell(pins_out.row_strobe_n) && pins_out.col_strobe_n != 4'hF
        |-> $past(pins_out.col_strobe_n) == 4'h0) else $error("refresh without column first");
    a_refresh_float: assert property (
        $fell(pins_out.row_strobe_n) && pins_out.col_strobe_n != 4'hF
        |-> dram_data_lines_oe_n_out) else $error("data driven in refresh");
    a_row_addr: assert property (
        $fell(pins_out.row_strobe_n) && pins_out.col_strobe_n == 4'hF
        |-> pins_out.addr == row_q && $past(pins_out.addr) == row_q) else $error("bad row");
    a_col_addr: assert property (
        $past(pins_out.col_strobe_n) == 4'hF && pins_out.col_strobe_n != 4'hF
        && !pins_out.row_strobe_n |-> pins_out.addr == col_q) else $error("bad column");
    a_xfer_code: assert property (
        $fell(pins_out.row_strobe_n) && !pins_out.transfer_output_enable_n
        |-> pins_out.mask_write_enable_n && !pins_out.special_function_select)
        else $error("bad transfer code");
    a_mask_drive: assert property (
        $fell(pins_out.row_strobe_n) && !pins_out.mask_write_enable_n
        |-> !dram_data_lines_oe_n_out) else $error("mask not driven");
    a_no_clash: assert property (
        !dram_data_lines_oe_n_out |-> pins_out.transfer_output_enable_n)
        else $error("data clash");
    a_read_answer: assert property (
        take && req_in.op == vdc_pkg::OP_READ |-> ##[8:10] rd_valid_out)
        else $error("no read answer");
    a_busy_hold: assert property (
        take |=> !req_ready_out [*8]) else $error("ready too early");
    a_gate_on: assert property (
        stream_enable_in |-> ##2 !pins_out.shift_port_gate_n) else $error("gate not open");
    a_shift_half: assert property (
        $rose(pins_out.shift_clock) |-> pins_out.shift_clock [*4] ##1 !pins_out.shift_clock)
        else $error("bad shift clock");
endmodule // vdc_chk
bind vdc_host vdc_chk #(.REFRESH_GAP(REFRESH_GAP)) u_chk (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid_in),
    .req_in(req_in),
    .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out),
    .stream_enable_in(stream_enable_in),
    .pins_out(pins_out),
    .dram_data_lines_oe_n_out(dram_data_lines_oe_n_out)
);
`default_nettype wire

// ### tb/vdc_vram_model.sv
// Behavioural dual-port video memory driven by the host's pins.
// Assumes pins change only at host clock edges; it also resolves the data wire.
`timescale 1ns/1ps
`default_nettype none
module vdc_vram_model (
    input wire vdc_pkg::vdc_pins_type pins_in,
    input wire logic [31:0] host_dq_in,
    input wire logic host_dq_oe_n_in,
    output logic [31:0] dq_wire_out,
    output logic [31:0] serial_out_lines_out,
    output logic half_status_flag_out
);
    logic [31:0] mem [bit [17:0]];
    logic [31:0] sbuf [512];
    logic [8:0] row_q = 9'h000;
    logic [8:0] col_q = 9'h000;
    logic [8:0] ptr_q = 9'h000;
    logic [31:0] mask_q = 32'hFFFFFFFF;
    logic [31:0] rdw = 32'h0;
    logic [31:0] w = 32'h0;
    logic [31:0] last_dq = 32'h0;
    logic [31:0] sword = 32'h0;
    logic [3:0] prev_q = 4'hF;
    logic xfer_q = 1'b0;
    logic cbr_q = 1'b0;
    int cbr_count = 0;
    // Unwritten words read back as their own address.
    function automatic logic [31:0] rd(input bit [17:0] a);
        return mem.exists(a) ? mem[a] : {14'h0000, a};
    endfunction
    // ====================================================================
    // Random-access port
    always @(negedge pins_in.row_strobe_n) begin
        row_q = pins_in.addr;
        cbr_q = pins_in.col_strobe_n != 4'hF;
        xfer_q = !pins_in.transfer_output_enable_n && !pins_in.special_function_select;
        mask_q = pins_in.mask_write_enable_n ? 32'hFFFFFFFF : dq_wire_out;
        if (cbr_q) cbr_count++;
    end
    always @(posedge pins_in.row_strobe_n) begin
        mask_q = 32'hFFFFFFFF;
        cbr_q = 1'b0;
        xfer_q = 1'b0;
    end
    always @(pins_in.col_strobe_n) begin
        for (int i = 0; i < 4; i++) begin
            if (prev_q[i] && !pins_in.col_strobe_n[i] && !pins_in.row_strobe_n && !cbr_q) begin
                col_q = pins_in.addr;
                if (xfer_q) begin
                    // The serial copy is static and never needs refreshing.
                    for (int j = 0; j < 512; j++)
                        sbuf[j] = rd({row_q, 9'(j)});
                    ptr_q = pins_in.addr;
                end else if (!pins_in.mask_write_enable_n && !pins_in.special_function_select) begin
                    w = rd({row_q, col_q});
                    w[8*i+:8] = (w[8*i+:8] & ~mask_q[8*i+:8]) | (dq_wire_out[8*i+:8] & mask_q[8*i+:8]);
                    mem[{row_q, col_q}] = w;
                end
                rdw = rd({row_q, col_q});
            end
        end
        prev_q = pins_in.col_strobe_n;
    end
    // An undriven lane shows the inverse of its last level, never a stale copy.
    always @(pins_in) last_dq <= dq_wire_out;
    always @* begin
        for (int i = 0; i < 4; i++) begin
            if (!host_dq_oe_n_in) dq_wire_out[8*i+:8] = host_dq_in[8*i+:8];
            else if (!pins_in.row_strobe_n && !cbr_q && !xfer_q && pins_in.mask_write_enable_n
                && !pins_in.transfer_output_enable_n && !pins_in.col_strobe_n[i])
                dq_wire_out[8*i+:8] = rdw[8*i+:8];
            else dq_wire_out[8*i+:8] = ~last_dq[8*i+:8];
        end
    end
    // ====================================================================
    // Serial port
    always @(posedge pins_in.shift_clock) begin
        sword = sbuf[ptr_q];
        ptr_q = ptr_q + 9'h001;
    end
    assign serial_out_lines_out = pins_in.shift_port_gate_n ? ~sword : sword;
    assign half_status_flag_out = ptr_q[8];
endmodule // vdc_vram_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for vdc_host against the behavioural memory model.
// Assumes a 20 MHz clock and a short refresh gap for a quick run.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int GAP = 20;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic req_valid = 1'b0;
    logic stream_enable = 1'b0;
    logic stream_ready = 1'b0;
    vdc_pkg::vdc_req_type req = '0;
    vdc_pkg::vdc_req_type rows [10];
    vdc_pkg::vdc_pins_type pins;
    logic req_ready, rd_valid, stream_valid, half_status, dq_oe_n, half_status_flag;
    logic [31:0] rd_data, stream_data, dq_out, dq_wire, sq;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    vdc_host #(.REFRESH_GAP(GAP), .FIFO_DEPTH(32)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .stream_enable_in(stream_enable),
        .stream_valid_out(stream_valid), .stream_data_out(stream_data),
        .stream_ready_in(stream_ready), .half_status_out(half_status), .pins_out(pins),
        .dram_data_lines_in(dq_wire), .dram_data_lines_out(dq_out),
        .dram_data_lines_oe_n_out(dq_oe_n), .serial_out_lines_in(sq), .half_status_flag_in(half_status_flag));
    vdc_vram_model m (.pins_in(pins), .host_dq_in(dq_out), .host_dq_oe_n_in(dq_oe_n),
        .dq_wire_out(dq_wire), .serial_out_lines_out(sq), .half_status_flag_out(half_status_flag));
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    // ====================================================================
    // Checking and driving tasks
    task automatic results();
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string s);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, s, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e, input string s);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: %s got %b expected %b", $time, s, g, e);
        end
    endtask
    task automatic send(input vdc_pkg::vdc_req_type r);
        int n;
        n = 0;
        req <= r;
        req_valid <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        req_valid <= 1'b0;
        @(posedge clk_in);
    endtask
    // Read rows carry the expected word in their data field.
    task automatic read_row(input vdc_pkg::vdc_req_type r);
        int n;
        logic [31:0] lm;
        n = 0;
        lm = {{8{r.lanes[3]}}, {8{r.lanes[2]}}, {8{r.lanes[1]}}, {8{r.lanes[0]}}};
        send(r);
        while (rd_valid !== 1'b1 && n < 30) begin
            @(posedge clk_in);
            n++;
        end
        chk32(rd_data & lm, r.data & lm, "read word");
    endtask
    function automatic logic [31:0] sexp(input logic [8:0] c);
        if (c == 9'h0FF) return 32'h5A5A5A5A;
        if (c == 9'h100) return 32'hA5A5A5A5;
        return {14'h0000, 9'h002, c};
    endfunction
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            results();
        end
    end
    // ====================================================================
    // Main sequence
    initial begin
        logic [8:0] p;
        int n;
        rows = '{'{vdc_pkg::OP_WRITE, 18'h0AAAA, 4'hF, 32'h11223344, 32'h0},
            '{vdc_pkg::OP_READ, 18'h0AAAA, 4'hF, 32'h11223344, 32'h0},
            '{vdc_pkg::OP_WRITE, 18'h0AAAA, 4'h5, 32'hAABBCCDD, 32'h0},
            '{vdc_pkg::OP_MWRITE, 18'h0AAAA, 4'hF, 32'h99999999, 32'h0000FFFF},
            '{vdc_pkg::OP_READ, 18'h0AAAA, 4'hF, 32'h11BB9999, 32'h0},
            '{vdc_pkg::OP_WRITE, 18'h3FFFF, 4'hF, 32'hCAFEF00D, 32'h0},
            '{vdc_pkg::OP_READ, 18'h3FFFF, 4'h2, 32'hCAFEF00D, 32'h0},
            '{vdc_pkg::OP_READ, 18'h00123, 4'hF, 32'h00000123, 32'h0},
            '{vdc_pkg::OP_WRITE, 18'h004FF, 4'hF, 32'h5A5A5A5A, 32'h0},
            '{vdc_pkg::OP_WRITE, 18'h00500, 4'hF, 32'hA5A5A5A5, 32'h0}};
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (300) @(posedge clk_in);
        chk1(m.cbr_count >= 8, 1'b1, "refresh count");
        for (int i = 0; i < 10; i++) begin
            if (rows[i].op == vdc_pkg::OP_READ) read_row(rows[i]);
            else send(rows[i]);
        end
        send('{vdc_pkg::OP_XFER, 18'h004FF, 4'hF, 32'h0, 32'h0});
        repeat (12) @(posedge clk_in);
        chk1(half_status, 1'b0, "half flag low");
        stream_enable <= 1'b1;
        read_row(rows[4]);
        repeat (400) @(posedge clk_in);
        p = m.ptr_q;
        repeat (40) @(posedge clk_in);
        chk32({23'h0, m.ptr_q}, {23'h0, p}, "shift stalled while full");
        chk1(stream_valid, 1'b1, "stream held");
        stream_ready <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            n = 0;
            do begin
                @(posedge clk_in);
                n++;
            end while (stream_valid !== 1'b1 && n < 30);
            chk32(stream_data, sexp(9'h0FF + 9'(k)), "stream word");
        end
        chk1(half_status, 1'b1, "half flag high");
        sys_rst_in <= 1'b1;
        stream_enable <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk1(pins == vdc_pkg::PINS_IDLE, 1'b1, "pins idle in reset");
        chk1(dq_oe_n, 1'b1, "data released in reset");
        sys_rst_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        results();
    end
endmodule // tb
`default_nettype wire
